// file: hw/adc_seq_params.svh
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// register byte offsets
`define ADC_OFS_CTRL 8'h00
`define ADC_OFS_SEL 8'h04
`define ADC_OFS_TRIG 8'h08
`define ADC_OFS_RESL 8'h0c
`define ADC_OFS_RESH 8'h10
`define ADC_OFS_STAT 8'h14

// control register fields
`define ADC_CTRL_EN 0
`define ADC_CTRL_START 1
`define ADC_CTRL_AUTO 2
`define ADC_CTRL_DONE 3
`define ADC_CTRL_DIV_LO 4
`define ADC_CTRL_DIV_HI 6

// selection register fields
`define ADC_SEL_CH_LO 0
`define ADC_SEL_CH_HI 4
`define ADC_SEL_REF_LO 6
`define ADC_SEL_REF_HI 7
`define ADC_SEL_DIFF_BIT 4

// reset values
`define ADC_RST_DIV 3'h0
`define ADC_RST_SEL 7'h00
`define ADC_RST_SRC 3'h0
`define ADC_RST_RES 10'h000

// free running trigger source code
`define ADC_SRC_FREE 3'h0

// timing in half converter clocks from conversion start
`define ADC_SH_NORMAL 6'h03
`define ADC_END_NORMAL 6'h1a
`define ADC_SH_FIRST 6'h1b
`define ADC_END_FIRST 6'h32
`define ADC_SH_TRIG 6'h04
`define ADC_END_TRIG 6'h1b
`define ADC_SH_DIFF_LATE 6'h05
`define ADC_END_DIFF_LATE 6'h1c
// selection unlocks in the last converter clock
`define ADC_UNLOCK_LEAD 6'h02

`endif

// file: hw/adc_seq_pkg.sv
package adc_seq_pkg;
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_WAIT = 2'b01,
		SEQ_CONV = 2'b10
	} seq_state_t;

	typedef logic [9:0] result_t;
	typedef logic [6:0] select_t;
endpackage

// file: hw/adc_prescaler.sv
`timescale 1ns/10ps
`include "adc_seq_params.svh"

module adc_prescaler (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic enable,
	input wire logic restart,
	input wire logic [2:0] div_sel,
	// converter clock enables
	output logic tick,
	output logic half_tick
);
	logic [6:0] cnt_q;
	logic [6:0] cnt_d;
	logic [7:0] div;

	// power of two divisor, select 0 also divides by two
	always_comb begin
		if (div_sel == 3'h0) begin
			div = 8'h02;
		end else begin
			div = 8'h01 << div_sel;
		end
	end

	assign tick = enable && !restart && ({1'b0, cnt_q} == div - 8'h01);
	assign half_tick = enable && !restart && ({1'b0, cnt_q} == (div >> 1) - 8'h01);

	// counter held at zero while disabled or on a trigger restart
	always_comb begin
		if (!enable || restart) begin
			cnt_d = 7'h00;
		end else if (tick) begin
			cnt_d = 7'h00;
		end else begin
			cnt_d = cnt_q + 7'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= 7'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

// file: hw/adc_conversion_sequencer.sv
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "adc_seq_params.svh"

module adc_conversion_sequencer (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// ahb-lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// trigger sources, index = source code
	input wire logic [7:1] TRIG_IN,
	// converter side
	input wire logic [9:0] RESULT_IN,
	output logic CONV_ENABLE,
	output logic CONV_CLK_EN,
	output logic HALF_RATE_SYNC_CLOCK,
	output logic CONV_BUSY,
	output logic SAMPLE_HOLD,
	output logic [4:0] CHANNEL_SELECT_BITS,
	output logic [1:0] REFERENCE_SELECT_BITS
);
	logic tick;
	logic half_tick;
	logic trig_go;

	// register state
	logic en_q, en_d, auto_q, auto_d, done_q, done_d, lock_q, lock_d;
	logic [2:0] div_q, div_d, src_q, src_d;
	adc_seq_pkg::select_t buf_q, buf_d, appl_q, appl_d;
	adc_seq_pkg::result_t res_q, res_d;
	// sequencer state
	adc_seq_pkg::seq_state_t st_q, st_d;
	logic first_q, first_d, half_q, half_d, hold_q, hold_d;
	logic [5:0] hcnt_q, hcnt_d, sh_q, sh_d, end_q, end_d;
	// bus state
	logic wr_q, wr_d;
	logic [7:0] wa_q, wa_d;
	logic [31:0] rd_q, rd_d;
	// synchronisers
	logic [7:1] tg1_q, tg2_q, tgp_q;
	logic [9:0] rs1_q, rs2_q;
	// registered outputs
	logic sh_out_q, sh_out_d, ck_out_q;

	logic acc;
	logic wr_ctrl, wr_sel, wr_trig;
	logic trig_lvl, trig_prev, diff_sel, free_run, step, conv_end, sw_start;
	logic [5:0] hnext;

	adc_prescaler u_prescaler (
		.clk(CORE_CLK),
		.rst(RST),
		.enable(en_q),
		.restart(trig_go),
		.div_sel(div_q),
		.tick(tick),
		.half_tick(half_tick)
	);

	// two flip-flop synchronisers, then edge history
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			tg1_q <= 7'h00;
			tg2_q <= 7'h00;
			tgp_q <= 7'h00;
			rs1_q <= 10'h000;
			rs2_q <= 10'h000;
		end else begin
			tg1_q <= TRIG_IN;
			tg2_q <= tg1_q;
			tgp_q <= tg2_q;
			rs1_q <= RESULT_IN;
			rs2_q <= rs1_q;
		end
	end

	// selected trigger and decode of modes
	always_comb begin
		trig_lvl = 1'b0;
		trig_prev = 1'b0;
		if (src_q != `ADC_SRC_FREE) begin
			trig_lvl = tg2_q[src_q];
			trig_prev = tgp_q[src_q];
		end
	end
	assign diff_sel = appl_q[`ADC_SEL_DIFF_BIT];
	assign free_run = auto_q && (src_q == `ADC_SRC_FREE);
	// pin, two flops, edge register: three cycles to start
	assign trig_go = en_q && auto_q && (src_q != `ADC_SRC_FREE) && (st_q != adc_seq_pkg::SEQ_CONV)
		&& trig_lvl && !trig_prev;
	assign step = (st_q == adc_seq_pkg::SEQ_CONV) && (tick || half_tick);
	assign hnext = hcnt_q + 6'h01;
	assign conv_end = step && (hnext == end_q);

	// ahb address phase and write decode
	assign acc = HSEL && HTRANS[1] && HREADY;
	assign wr_ctrl = wr_q && (wa_q == `ADC_OFS_CTRL);
	assign wr_sel = wr_q && (wa_q == `ADC_OFS_SEL);
	assign wr_trig = wr_q && (wa_q == `ADC_OFS_TRIG);
	assign sw_start = wr_ctrl && HWDATA[`ADC_CTRL_START];

	// bus pipeline and read data
	always_comb begin
		wr_d = acc && HWRITE;
		wa_d = acc ? HADDR[7:0] : wa_q;
		rd_d = 32'h0000_0000;
		if (acc && !HWRITE) begin
			unique case (HADDR[7:0])
				`ADC_OFS_CTRL: rd_d = {25'h0, div_q, done_q, auto_q,
					st_q != adc_seq_pkg::SEQ_IDLE, en_q};
				`ADC_OFS_SEL: rd_d = {24'h0, buf_q[6:5], 1'b0, buf_q[4:0]};
				`ADC_OFS_TRIG: rd_d = {29'h0, src_q};
				`ADC_OFS_RESL: rd_d = {24'h0, res_q[7:0]};
				`ADC_OFS_RESH: rd_d = {30'h0, res_q[9:8]};
				`ADC_OFS_STAT: rd_d = {28'h0, lock_q, first_q, half_q, st_q == adc_seq_pkg::SEQ_CONV};
				default: rd_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
			rd_q <= 32'h0000_0000;
		end else begin
			wr_q <= wr_d;
			wa_q <= wa_d;
			rd_q <= rd_d;
		end
	end

	// software registers, result and selection
	always_comb begin
		en_d = en_q;
		auto_d = auto_q;
		div_d = div_q;
		src_d = src_q;
		buf_d = buf_q;
		done_d = done_q;
		res_d = res_q;
		lock_d = lock_q;
		appl_d = appl_q;
		if (wr_ctrl) begin
			en_d = HWDATA[`ADC_CTRL_EN];
			auto_d = HWDATA[`ADC_CTRL_AUTO];
			div_d = HWDATA[`ADC_CTRL_DIV_HI:`ADC_CTRL_DIV_LO];
			if (HWDATA[`ADC_CTRL_DONE]) begin
				done_d = 1'b0;
			end
		end
		if (wr_trig) begin
			src_d = HWDATA[2:0];
		end
		if (wr_sel) begin
			buf_d = {HWDATA[`ADC_SEL_REF_HI:`ADC_SEL_REF_LO],
				HWDATA[`ADC_SEL_CH_HI:`ADC_SEL_CH_LO]};
		end
		// low byte read locks, high byte read releases
		if (acc && !HWRITE && HADDR[7:0] == `ADC_OFS_RESL) begin
			lock_d = 1'b1;
		end else if (acc && !HWRITE && HADDR[7:0] == `ADC_OFS_RESH) begin
			lock_d = 1'b0;
		end
		// completion: set wins over a clear in the same cycle
		if (conv_end) begin
			done_d = 1'b1;
			if (!lock_q) begin
				res_d = rs2_q;
			end
		end
		// copy buffer only while enabled and not frozen by a conversion
		if (en_q && !hold_q) begin
			appl_d = buf_q;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			en_q <= 1'b0;
			auto_q <= 1'b0;
			div_q <= `ADC_RST_DIV;
			src_q <= `ADC_RST_SRC;
			buf_q <= `ADC_RST_SEL;
			done_q <= 1'b0;
			res_q <= `ADC_RST_RES;
			lock_q <= 1'b0;
			appl_q <= `ADC_RST_SEL;
		end else begin
			en_q <= en_d;
			auto_q <= auto_d;
			div_q <= div_d;
			src_q <= src_d;
			buf_q <= buf_d;
			done_q <= done_d;
			res_q <= res_d;
			lock_q <= lock_d;
			appl_q <= appl_d;
		end
	end

	// conversion sequencer
	always_comb begin
		st_d = st_q;
		first_d = first_q;
		half_d = half_q;
		hold_d = hold_q;
		hcnt_d = hcnt_q;
		sh_d = sh_q;
		end_d = end_q;
		sh_out_d = 1'b0;
		// half-rate clock restarts with the prescaler
		if (!en_q || trig_go) begin
			half_d = 1'b0;
		end else if (tick) begin
			half_d = !half_q;
		end
		if (wr_ctrl && HWDATA[`ADC_CTRL_EN] && !en_q) begin
			first_d = 1'b1;
		end
		unique case (st_q)
			adc_seq_pkg::SEQ_IDLE: begin
				if (trig_go) begin
					st_d = adc_seq_pkg::SEQ_CONV;
					hcnt_d = 6'h00;
					hold_d = 1'b1;
					if (first_q || diff_sel) begin
						sh_d = `ADC_SH_FIRST;
						end_d = `ADC_END_FIRST;
					end else begin
						sh_d = `ADC_SH_TRIG;
						end_d = `ADC_END_TRIG;
					end
				end else if (sw_start && en_d) begin
					st_d = adc_seq_pkg::SEQ_WAIT;
				end
			end
			adc_seq_pkg::SEQ_WAIT: begin
				if (tick) begin
					st_d = adc_seq_pkg::SEQ_CONV;
					hcnt_d = 6'h00;
					hold_d = 1'b1;
					if (first_q) begin
						sh_d = `ADC_SH_FIRST;
						end_d = `ADC_END_FIRST;
					end else if (diff_sel && half_q) begin
						sh_d = `ADC_SH_DIFF_LATE;
						end_d = `ADC_END_DIFF_LATE;
					end else begin
						sh_d = `ADC_SH_NORMAL;
						end_d = `ADC_END_NORMAL;
					end
				end
			end
			adc_seq_pkg::SEQ_CONV: begin
				if (step) begin
					hcnt_d = hnext;
					if (hnext == sh_q) begin
						sh_out_d = 1'b1;
					end
					if (hnext >= end_q - `ADC_UNLOCK_LEAD) begin
						hold_d = 1'b0;
					end
				end
				if (conv_end) begin
					first_d = 1'b0;
					if (free_run) begin
						hcnt_d = 6'h00;
						hold_d = 1'b1;
						sh_d = diff_sel ? `ADC_SH_DIFF_LATE : `ADC_SH_NORMAL;
						end_d = diff_sel ? `ADC_END_DIFF_LATE : `ADC_END_NORMAL;
					end else begin
						st_d = adc_seq_pkg::SEQ_IDLE;
					end
				end
			end
			default: st_d = adc_seq_pkg::SEQ_IDLE;
		endcase
		// disabling aborts everything, enabling with start proceeds
		if (!en_d) begin
			st_d = adc_seq_pkg::SEQ_IDLE;
			hold_d = 1'b0;
			sh_out_d = 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			st_q <= adc_seq_pkg::SEQ_IDLE;
			first_q <= 1'b0;
			half_q <= 1'b0;
			hold_q <= 1'b0;
			hcnt_q <= 6'h00;
			sh_q <= `ADC_SH_NORMAL;
			end_q <= `ADC_END_NORMAL;
			sh_out_q <= 1'b0;
			ck_out_q <= 1'b0;
		end else begin
			st_q <= st_d;
			first_q <= first_d;
			half_q <= half_d;
			hold_q <= hold_d;
			hcnt_q <= hcnt_d;
			sh_q <= sh_d;
			end_q <= end_d;
			sh_out_q <= sh_out_d;
			ck_out_q <= tick;
		end
	end

	// outputs straight from flops, CONV_BUSY through a decode of st_q, HREADYOUT and HRESP tied off
	assign HRDATA = rd_q;
	assign HREADYOUT = 1'b1 | rd_q[0] & 1'b0;
	assign HRESP = 1'b0;
	assign CONV_ENABLE = en_q;
	assign CONV_CLK_EN = ck_out_q;
	assign HALF_RATE_SYNC_CLOCK = half_q;
	assign CONV_BUSY = st_q == adc_seq_pkg::SEQ_CONV;
	assign SAMPLE_HOLD = sh_out_q;
	assign CHANNEL_SELECT_BITS = appl_q[4:0];
	assign REFERENCE_SELECT_BITS = appl_q[6:5];
endmodule

// file: test/adc_seq_assertions.sv
`timescale 1ns/10ps
module adc_seq_assertions (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// watched outputs
	input wire logic HREADYOUT,
	input wire logic CONV_ENABLE,
	input wire logic CONV_CLK_EN,
	input wire logic HALF_RATE_SYNC_CLOCK,
	input wire logic CONV_BUSY,
	input wire logic SAMPLE_HOLD,
	input wire logic [4:0] CHANNEL_SELECT_BITS,
	input wire logic [1:0] REFERENCE_SELECT_BITS
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	logic [5:0] tk_q;
	logic [5:0] tk_d;
	// ticks seen in a conversion
	always_comb begin
		tk_d = tk_q;
		if (!CONV_BUSY) tk_d = 6'h00;
		else if (CONV_CLK_EN && tk_q != 6'h3f) tk_d = tk_q + 6'h01;
	end
	always_ff @(posedge CORE_CLK) begin
		tk_q <= RST ? 6'h00 : tk_d;
	end
	property p_held;
		!CONV_ENABLE && !$past(CONV_ENABLE) |-> !CONV_CLK_EN && !CONV_BUSY;
	endproperty
	a_held: assert property (p_held) else $error("converter active while disabled");
	property p_half;
		!CONV_ENABLE && !$past(CONV_ENABLE) |-> !HALF_RATE_SYNC_CLOCK;
	endproperty
	a_half: assert property (p_half) else $error("half rate clock runs disabled");
	property p_pulse;
		CONV_CLK_EN |=> !CONV_CLK_EN;
	endproperty
	a_pulse: assert property (p_pulse) else $error("tick wider than one cycle");
	property p_sh_busy;
		SAMPLE_HOLD |-> CONV_BUSY;
	endproperty
	a_sh_busy: assert property (p_sh_busy) else $error("sample outside conversion");
	property p_sh_one;
		SAMPLE_HOLD |=> !SAMPLE_HOLD [*2];
	endproperty
	a_sh_one: assert property (p_sh_one) else $error("sample pulse repeated");
	property p_sh_late;
		$rose(CONV_BUSY) |-> !SAMPLE_HOLD ##1 !SAMPLE_HOLD;
	endproperty
	a_sh_late: assert property (p_sh_late) else $error("sample too early");
	property p_lock;
		$rose(CONV_BUSY) |=> ($stable(CHANNEL_SELECT_BITS) && $stable(REFERENCE_SELECT_BITS)) [*8];
	endproperty
	a_lock: assert property (p_lock) else $error("selection moved in conversion");
	property p_len;
		$fell(CONV_BUSY) && CONV_ENABLE |-> tk_q >= 6'h0c && tk_q <= 6'h1a;
	endproperty
	a_len: assert property (p_len) else $error("conversion length wrong");
	property p_bus;
		HREADYOUT;
	endproperty
	a_bus: assert property (p_bus) else $error("bus stalled");
	c_done: cover property ($fell(CONV_BUSY));
	c_diff: cover property (SAMPLE_HOLD && CHANNEL_SELECT_BITS[4]);
	c_on: cover property ($rose(CONV_ENABLE));
endmodule
bind adc_conversion_sequencer adc_seq_assertions i_adc_seq_assertions (
	.CORE_CLK(CORE_CLK), .RST(RST), .HREADYOUT(HREADYOUT), .CONV_ENABLE(CONV_ENABLE),
	.CONV_CLK_EN(CONV_CLK_EN), .HALF_RATE_SYNC_CLOCK(HALF_RATE_SYNC_CLOCK),
	.CONV_BUSY(CONV_BUSY), .SAMPLE_HOLD(SAMPLE_HOLD),
	.CHANNEL_SELECT_BITS(CHANNEL_SELECT_BITS), .REFERENCE_SELECT_BITS(REFERENCE_SELECT_BITS)
);

// file: test/adc_analog_model.sv
`timescale 1ns/10ps
module adc_analog_model (
	// clock
	input wire logic clk,
	// converter side
	input wire logic sample_hold,
	input wire logic [4:0] channel,
	input wire logic [1:0] reference,
	output logic [9:0] result,
	output logic [7:0] sh_cnt
);
	initial begin
		result = 10'h000;
		sh_cnt = 8'h00;
	end
	// result encodes the selection held at the sample instant
	always @(posedge clk) begin
		if (sample_hold) begin
			result <= {1'b1, reference, channel, 2'h2};
			sh_cnt <= sh_cnt + 8'h01;
		end
	end
endmodule

// file: test/testbench.sv
`timescale 1ns/10ps
`include "adc_seq_params.svh"
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [7:1] trig = 7'h00;
	logic [31:0] hrdata, rd_q;
	logic hro, hresp, en, cke, half, busy, sh, rdy_q;
	logic [4:0] ch;
	logic [1:0] rf;
	logic [9:0] res;
	logic [7:0] shc;
	int error_cnt = 0;
	int total_checks = 0;
	localparam logic [9:0] res_a = {1'b1, 2'h1, 5'h03, 2'h2};
	always #20 clk = ~clk;
	// bus answer as seen at the edge
	always @(posedge clk) begin
		rd_q <= hrdata;
		rdy_q <= hro;
	end
	adc_conversion_sequencer i_adc_conversion_sequencer (.CORE_CLK(clk), .RST(rst),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
		.HWDATA(hwdata), .HREADY(hro), .HRDATA(hrdata), .HREADYOUT(hro), .HRESP(hresp),
		.TRIG_IN(trig), .RESULT_IN(res), .CONV_ENABLE(en), .CONV_CLK_EN(cke),
		.HALF_RATE_SYNC_CLOCK(half), .CONV_BUSY(busy), .SAMPLE_HOLD(sh),
		.CHANNEL_SELECT_BITS(ch), .REFERENCE_SELECT_BITS(rf));
	adc_analog_model i_adc_analog_model (.clk(clk), .sample_hold(sh), .channel(ch),
		.reference(rf), .result(res), .sh_cnt(shc));
	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// one edge per step, bounded wait on a condition
	task automatic tick(output int n, input int what);
		n = 0;
		do begin
			@(posedge clk) #1;
			n++;
		end while (!(what == 0 ? rdy_q === 1'b1 : what == 1 ? busy === 1'b1 :
			what == 2 ? busy === 1'b0 : sh === 1'b1) && n < 900);
		if (n >= 900) begin
			error_cnt++;
			stop_test;
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		tick(n, 0);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		tick(n, 0);
		r = rd_q;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x, e);
	endtask
	// length of a conversion and where it sampled
	task automatic conv(output int len, output int sho);
		int n;
		tick(n, 1);
		len = 0;
		sho = -1;
		while (busy === 1'b1 && len < 900) begin
			if (sh === 1'b1) sho = len;
			@(posedge clk) #1;
			len++;
		end
	endtask
	task automatic s_reset;
		rd(`ADC_OFS_CTRL, 32'h0);
		rd(`ADC_OFS_SEL, {25'h0, `ADC_RST_SEL});
		rd(`ADC_OFS_STAT, 32'h0);
		rd(8'h18, 32'h0);
	endtask
	task automatic s_first;
		int len, sho;
		wr(`ADC_OFS_SEL, 32'h43);
		chk(ch, 5'h00);
		wr(`ADC_OFS_CTRL, 32'h03);
		conv(len, sho);
		chk(len, 50);
		chk(sho, 27);
		chk({rf, ch}, 7'h23);
		rd(`ADC_OFS_CTRL, 32'h09);
		rd(`ADC_OFS_RESL, res_a[7:0]);
		rd(`ADC_OFS_RESH, res_a[9:8]);
	endtask
	task automatic s_div;
		int len, sho;
		for (int d = 1; d < 4; d++) begin
			wr(`ADC_OFS_CTRL, 32'h0b | (d << 4));
			conv(len, sho);
			chk(len, 26 << (d - 1));
			chk(sho, 3 << (d - 1));
		end
	endtask
	task automatic s_lock;
		int n;
		rd(`ADC_OFS_RESL, res_a[7:0]);
		wr(`ADC_OFS_SEL, 32'h05);
		wr(`ADC_OFS_CTRL, 32'h0b);
		tick(n, 1);
		wr(`ADC_OFS_SEL, 32'h06);
		chk(ch, 5'h05);
		tick(n, 2);
		chk(ch, 5'h06);
		rd(`ADC_OFS_CTRL, 32'h09);
		rd(`ADC_OFS_RESH, res_a[9:8]);
		rd(`ADC_OFS_RESL, res_a[7:0]);
	endtask
	task automatic s_free;
		int n;
		wr(`ADC_OFS_TRIG, {29'h0, `ADC_SRC_FREE});
		wr(`ADC_OFS_SEL, 32'h10);
		repeat (3125) @(posedge clk);
		wr(`ADC_OFS_CTRL, 32'h0f);
		tick(n, 3);
		tick(n, 3);
		tick(n, 3);
		chk(n, 28);
		chk(busy, 1'b1);
		rd(`ADC_OFS_CTRL, 32'h0f);
		wr(`ADC_OFS_CTRL, 32'h00);
		tick(n, 2);
	endtask
	task automatic s_trig;
		int n, len, sho;
		logic [7:0] c;
		wr(`ADC_OFS_SEL, 32'h02);
		wr(`ADC_OFS_TRIG, 32'h03);
		wr(`ADC_OFS_CTRL, 32'h03);
		conv(len, sho);
		chk(len, 50);
		wr(`ADC_OFS_CTRL, 32'h0d);
		trig[3] <= 1'b1;
		tick(n, 3);
		chk(n, 7);
		trig[3] <= 1'b0;
		tick(n, 0);
		trig[3] <= 1'b1;
		c = shc;
		repeat (90) @(posedge clk);
		#1;
		chk(busy, 1'b0);
		chk(shc, c);
		rd(`ADC_OFS_CTRL, 32'h0d);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk) #1;
		s_reset;
		s_first;
		s_div;
		s_lock;
		s_free;
		s_trig;
		stop_test;
	end
endmodule
